// file: src/slf_framer.sv
// Header framer: builds and parses message headers, keeps the
// sequence counters and link ownership, APB register access.
// Assumes a neighbour appends and checks the CRC fields and
// reports message completion; line bytes arrive on mclk_i.
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "slf_map.svh"
// How it works
// [RULE_01] First byte is a control-character class code with even parity on top
// [RULE_02] Class codes pick data, control or maintenance message
// [RULE_03] Next two bytes split into a 14-bit and a 2-bit field
// [RULE_04] Data and maintenance count locates the end of the information field
// [RULE_05] Control messages put type in low 8 bits, upper 6 bits zero
// [RULE_06] Negative acknowledge carries a six-bit reason in the upper bits
// [RULE_07] Two-bit field holds quick-sync and select flags
// [RULE_08] Quick-sync seen puts receiver into sync hunt and strip
// [RULE_09] Sync characters after quick-sync are discarded until next message
// [RULE_10] Only one transmitter at a time on managed links
// [RULE_11] Selected with own address grants transmit after reception ends
// [RULE_12] Sending select flag yields the link once message is sent
// [RULE_13] Data, ack and nak carry last correctly received number
// [RULE_14] Nak with response N marks message N plus one for resending
// [RULE_15] Data carries sender sequence number, counted modulo 256
// [RULE_16] Reply request carries the last sent number
// [RULE_17] Multipoint address field names the tributary both ways
// [RULE_18] Point-to-point sends address 1 and ignores received address
// [RULE_19] Only data and maintenance carry an information field
// [RULE_20] Start resets counters and is answered by start acknowledge
// [RULE_21] Header and information field each have their own check
// [RULE_22] Received counter advances only on exactly next number
// [RULE_23] No more than 127 unacknowledged data messages outstanding
// [RULE_24] Bad class or parity byte is dropped without counter changes
// [RULE_25] Count low byte first, flags in top two bits of second byte
module slf_framer #(
    parameter logic [7:0] WIN_MAX = `SLF_WIN_MAX
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [7:0]  rx_byte_i,
    input  wire logic        rx_valid_i,
    input  wire logic        rx_crc_ok_i,
    output logic      [7:0]  rx_info_o,
    output logic             rx_info_valid_o,
    output logic             rx_hunt_o,
    output logic      [7:0]  tx_byte_o,
    output logic             tx_valid_o,
    input  wire logic        tx_ready_i,
    input  wire logic        tx_done_i,
    output logic             link_own_o
);
    logic [31:0]         prdata_reg, prdata_next;
    logic                pready_reg, pready_next;
    logic                pslverr_reg, pslverr_next;
    logic [1:0]          ctrl_reg, ctrl_next;
    logic [7:0]          stn_reg, stn_next;
    slf_pkg::slf_cmd_s   cmd_reg, cmd_next;
    logic                pend_reg, pend_next;
    logic                stack_reg, stack_next;
    logic [7:0]          txn_reg, txn_next;
    logic [7:0]          ack_reg, ack_next;
    logic [7:0]          rxn_reg, rxn_next;
    logic [7:0]          retx_reg, retx_next;
    logic [5:0]          ev_reg, ev_next;
    slf_pkg::slf_rxhdr_s rh_reg, rh_next;
    slf_pkg::slf_tst_e   tst_reg, tst_next;
    slf_pkg::slf_rst_e   rst_reg, rst_next;
    logic [7:0]          hb_reg [0:5];
    logic [7:0]          hb_next [0:5];
    logic [2:0]          tidx_reg, tidx_next;
    logic                tsel_reg, tsel_next;
    logic [2:0]          ridx_reg, ridx_next;
    logic [7:0]          rcls_reg, rcls_next;
    logic [7:0]          raddr_reg, raddr_next;
    logic [14:0]         rcnt_reg, rcnt_next;
    logic [7:0]          rinfo_reg, rinfo_next;
    logic                rinfov_reg, rinfov_next;
    logic                hunt_reg, hunt_next;
    logic [7:0]          txb_reg, txb_next;
    logic                txv_reg, txv_next;
    logic                link_reg, link_next;
    logic                acc;
    logic                hit;
    logic [5:0]          evset;
    logic [7:0]          addr_out;
    logic [7:0]          outst;
    logic                rx_class;
    logic                rx_mine;
    logic                rx_end;

    always_comb begin
        acc       = psel_i & penable_i & ~pready_reg;
        addr_out  = ctrl_reg[0] ? stn_reg : `SLF_P2P_ADDR; // RULE_17
        outst     = 8'(txn_reg - ack_reg);
        rx_class  = (rx_byte_i == `SLF_CLS_DATA) || (rx_byte_i == `SLF_CLS_CTRL)
                 || (rx_byte_i == `SLF_CLS_MAINT); // RULE_01
        rx_mine   = ~ctrl_reg[0] || (raddr_reg == stn_reg); // RULE_18
        rx_end    = 1'b0;
        evset     = 6'h00;
        hit       = 1'b1;
        prdata_next  = 32'h0000_0000;
        pready_next  = acc;
        pslverr_next = 1'b0;
        ctrl_next  = ctrl_reg;
        stn_next   = stn_reg;
        cmd_next   = cmd_reg;
        pend_next  = pend_reg;
        stack_next = stack_reg;
        txn_next   = txn_reg;
        ack_next   = ack_reg;
        rxn_next   = rxn_reg;
        retx_next  = retx_reg;
        rh_next    = rh_reg;
        tst_next   = tst_reg;
        rst_next   = rst_reg;
        hb_next    = hb_reg;
        tidx_next  = tidx_reg;
        tsel_next  = tsel_reg;
        ridx_next  = ridx_reg;
        rcls_next  = rcls_reg;
        raddr_next = raddr_reg;
        rcnt_next  = rcnt_reg;
        rinfo_next = rinfo_reg;
        rinfov_next = 1'b0;
        hunt_next  = hunt_reg;
        txb_next   = txb_reg;
        txv_next   = txv_reg;
        link_next  = link_reg;

        // Register access
        unique case (paddr_i)
            `SLF_A_CTRL:    prdata_next = {29'h0, link_reg, ctrl_reg};
            `SLF_A_STATION: prdata_next = {24'h0, stn_reg};
            `SLF_A_TXCMD:   prdata_next = cmd_reg;
            `SLF_A_STATUS:  prdata_next = {retx_reg, ack_reg, rxn_reg, txn_reg};
            `SLF_A_RXHDR:   prdata_next = rh_reg;
            `SLF_A_EVENT:   prdata_next = {21'h0, pend_reg, ~tst_reg[0], link_reg,
                                           2'h0, ev_reg};
            default:        hit = 1'b0;
        endcase
        if (!acc || pwrite_i) begin
            prdata_next = 32'h0000_0000;
        end
        if (acc) begin
            pslverr_next = ~hit;
        end
        if (acc && pwrite_i) begin
            unique case (paddr_i)
                `SLF_A_CTRL: begin
                    ctrl_next = pwdata_i[1:0];
                    if (pwdata_i[2]) begin
                        link_next = 1'b1;
                    end
                end
                `SLF_A_STATION: stn_next = pwdata_i[7:0];
                `SLF_A_TXCMD: begin
                    cmd_next  = pwdata_i;
                    pend_next = 1'b1;
                end
                default: ;
            endcase
        end

        // Transmit side
        unique case (tst_reg)
            slf_pkg::SLF_T_IDLE: begin
                if ((!ctrl_reg[1] || link_reg) && (stack_reg || pend_reg)) begin // RULE_10
                    tst_next  = slf_pkg::SLF_T_SEND;
                    tidx_next = 3'h0;
                    txv_next  = 1'b1;
                    hb_next[5] = addr_out; // RULE_17 RULE_18
                    if (stack_reg) begin // RULE_20
                        stack_next = 1'b0;
                        tsel_next  = 1'b0;
                        hb_next[0] = `SLF_CLS_CTRL;
                        hb_next[1] = `SLF_T_STACK;
                        hb_next[2] = 8'h00;
                        hb_next[3] = 8'h00;
                        hb_next[4] = 8'h00;
                    end else begin
                        pend_next  = acc && pwrite_i && paddr_i == `SLF_A_TXCMD;
                        tsel_next  = cmd_reg.sel;
                        hb_next[2] = {cmd_reg.sel, cmd_reg.qsync, cmd_reg.cnt[13:8]}; // RULE_07 RULE_25
                        hb_next[1] = cmd_reg.cnt[7:0]; // RULE_03 RULE_25
                        hb_next[3] = 8'h00;
                        hb_next[4] = 8'h00;
                        unique case (cmd_reg.cls)
                            slf_pkg::SLF_C_DATA: begin
                                hb_next[0] = `SLF_CLS_DATA; // RULE_02
                                hb_next[3] = rxn_reg; // RULE_13
                                hb_next[4] = 8'(txn_reg + 8'h01); // RULE_15
                                if (outst >= WIN_MAX) begin // RULE_23
                                    tst_next = slf_pkg::SLF_T_IDLE;
                                    txv_next = 1'b0;
                                    evset[`SLF_EV_REFUSE] = 1'b1;
                                end else begin
                                    txn_next = 8'(txn_reg + 8'h01); // RULE_15
                                end
                            end
                            slf_pkg::SLF_C_MAINT: begin
                                hb_next[0] = `SLF_CLS_MAINT; // RULE_02
                            end
                            default: begin
                                hb_next[0] = `SLF_CLS_CTRL; // RULE_19
                                hb_next[1] = cmd_reg.ctype; // RULE_05
                                hb_next[2] = {cmd_reg.sel, cmd_reg.qsync, 6'h00}; // RULE_05
                                if (cmd_reg.ctype == `SLF_T_NAK) begin
                                    hb_next[2][5:0] = cmd_reg.reason; // RULE_06
                                end
                                if (cmd_reg.ctype == `SLF_T_ACK
                                    || cmd_reg.ctype == `SLF_T_NAK) begin
                                    hb_next[3] = rxn_reg; // RULE_13
                                end
                                if (cmd_reg.ctype == `SLF_T_REP) begin
                                    hb_next[4] = txn_reg; // RULE_16
                                end
                            end
                        endcase
                    end
                    txb_next = hb_next[0];
                end
            end
            slf_pkg::SLF_T_SEND: begin
                if (tx_ready_i) begin
                    if (tidx_reg == `SLF_TX_LAST) begin
                        txv_next = 1'b0;
                        tst_next = slf_pkg::SLF_T_WAIT;
                    end else begin
                        tidx_next = 3'(tidx_reg + 3'h1);
                        txb_next  = hb_reg[3'(tidx_reg + 3'h1)];
                    end
                end
            end
            slf_pkg::SLF_T_WAIT: begin
                if (tx_done_i) begin
                    tst_next = slf_pkg::SLF_T_IDLE;
                    if (tsel_reg && ctrl_reg[1]) begin
                        link_next = 1'b0; // RULE_12
                    end
                end
            end
        endcase

        // Receive side
        if (rx_valid_i) begin
            unique case (rst_reg)
                slf_pkg::SLF_R_HUNT: begin
                    if (rx_class) begin
                        hunt_next = 1'b0;
                        rcls_next = rx_byte_i;
                        ridx_next = 3'h1;
                        rst_next  = slf_pkg::SLF_R_HDR;
                    end else if (!(hunt_reg && rx_byte_i == `SLF_SYNC_CHAR)) begin // RULE_09
                        evset[`SLF_EV_BAD] = 1'b1; // RULE_24
                    end
                end
                slf_pkg::SLF_R_HDR: begin
                    ridx_next = 3'(ridx_reg + 3'h1);
                    unique case (ridx_reg)
                        3'h1: rh_next.cnt[7:0] = rx_byte_i; // RULE_25
                        3'h2: begin
                            rh_next.cnt[13:8] = rx_byte_i[5:0]; // RULE_03
                            rh_next.qsync     = rx_byte_i[6]; // RULE_07
                            rh_next.sel       = rx_byte_i[7];
                        end
                        3'h3: rh_next.response_number = rx_byte_i;
                        3'h4: rh_next.seq  = rx_byte_i;
                        3'h5: raddr_next   = rx_byte_i;
                        default: ;
                    endcase
                    if (ridx_reg == `SLF_HDR_LAST) begin
                        rst_next = slf_pkg::SLF_R_HUNT;
                        if (rx_crc_ok_i && rx_mine) begin // RULE_21 RULE_18
                            if (rcls_reg == `SLF_CLS_CTRL) begin
                                rx_end = 1'b1; // RULE_19
                                unique case (rh_reg.cnt[7:0])
                                    `SLF_T_ACK: ack_next = rh_reg.response_number;
                                    `SLF_T_NAK: begin
                                        ack_next  = rh_reg.response_number;
                                        retx_next = 8'(rh_reg.response_number + 8'h01); // RULE_14
                                        evset[`SLF_EV_NAK] = 1'b1;
                                    end
                                    `SLF_T_REP: evset[`SLF_EV_REP] = 1'b1;
                                    `SLF_T_START: begin
                                        txn_next   = 8'h00; // RULE_20
                                        ack_next   = 8'h00;
                                        rxn_next   = 8'h00;
                                        retx_next  = 8'h00;
                                        stack_next = 1'b1;
                                        evset[`SLF_EV_START] = 1'b1;
                                    end
                                    `SLF_T_STACK: evset[`SLF_EV_STACK] = 1'b1;
                                    default: ;
                                endcase
                            end else begin
                                if (rcls_reg == `SLF_CLS_DATA) begin
                                    ack_next = rh_reg.response_number; // RULE_13
                                end
                                rcnt_next = {1'b0, rh_reg.cnt} + 15'h0002; // RULE_04
                                rst_next  = slf_pkg::SLF_R_INFO;
                            end
                        end
                    end
                end
                slf_pkg::SLF_R_INFO: begin
                    rcnt_next = 15'(rcnt_reg - 15'h0001);
                    if (rcnt_reg > 15'h0002) begin
                        rinfo_next  = rx_byte_i;
                        rinfov_next = 1'b1;
                    end
                    if (rcnt_reg == 15'h0001) begin // RULE_04
                        rst_next = slf_pkg::SLF_R_HUNT;
                        rx_end   = 1'b1;
                        if (rcls_reg == `SLF_CLS_DATA && rx_crc_ok_i
                            && rh_reg.seq == 8'(rxn_reg + 8'h01)) begin
                            rxn_next = rh_reg.seq; // RULE_22
                        end
                    end
                end
            endcase
        end
        if (rx_end) begin
            hunt_next = rh_reg.qsync; // RULE_08
            if (rh_reg.sel && ctrl_reg[1]) begin
                link_next = 1'b1; // RULE_11
            end
        end

        // Sticky events, a new event wins over a clear
        ev_next = ev_reg;
        if (acc && pwrite_i && paddr_i == `SLF_A_EVENT) begin
            ev_next = ev_reg & ~pwdata_i[5:0];
        end
        ev_next = ev_next | evset;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            ctrl_reg    <= `SLF_CTRL_RST;
            stn_reg     <= `SLF_STN_RST;
            cmd_reg     <= '0;
            pend_reg    <= 1'b0;
            stack_reg   <= 1'b0;
            txn_reg     <= 8'h00;
            ack_reg     <= 8'h00;
            rxn_reg     <= 8'h00;
            retx_reg    <= 8'h00;
            ev_reg      <= 6'h00;
            rh_reg      <= '0;
            tst_reg     <= slf_pkg::SLF_T_IDLE;
            rst_reg     <= slf_pkg::SLF_R_HUNT;
            for (int i = 0; i < 6; i++) begin
                hb_reg[i] <= 8'h00;
            end
            tidx_reg    <= 3'h0;
            tsel_reg    <= 1'b0;
            ridx_reg    <= 3'h0;
            rcls_reg    <= 8'h00;
            raddr_reg   <= 8'h00;
            rcnt_reg    <= 15'h0000;
            rinfo_reg   <= 8'h00;
            rinfov_reg  <= 1'b0;
            hunt_reg    <= 1'b0;
            txb_reg     <= 8'h00;
            txv_reg     <= 1'b0;
            link_reg    <= 1'b0;
        end else begin
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            ctrl_reg    <= ctrl_next;
            stn_reg     <= stn_next;
            cmd_reg     <= cmd_next;
            pend_reg    <= pend_next;
            stack_reg   <= stack_next;
            txn_reg     <= txn_next;
            ack_reg     <= ack_next;
            rxn_reg     <= rxn_next;
            retx_reg    <= retx_next;
            ev_reg      <= ev_next;
            rh_reg      <= rh_next;
            tst_reg     <= tst_next;
            rst_reg     <= rst_next;
            hb_reg      <= hb_next;
            tidx_reg    <= tidx_next;
            tsel_reg    <= tsel_next;
            ridx_reg    <= ridx_next;
            rcls_reg    <= rcls_next;
            raddr_reg   <= raddr_next;
            rcnt_reg    <= rcnt_next;
            rinfo_reg   <= rinfo_next;
            rinfov_reg  <= rinfov_next;
            hunt_reg    <= hunt_next;
            txb_reg     <= txb_next;
            txv_reg     <= txv_next;
            link_reg    <= link_next;
        end
    end

    assign prdata_o        = prdata_reg;
    assign pready_o        = pready_reg;
    assign pslverr_o       = pslverr_reg;
    assign rx_info_o       = rinfo_reg;
    assign rx_info_valid_o = rinfov_reg;
    assign rx_hunt_o       = hunt_reg;
    assign tx_byte_o       = txb_reg;
    assign tx_valid_o      = txv_reg;
    assign link_own_o      = link_reg;
endmodule

// file: common/slf_map.svh
// Offsets, field codes, reset values and limits of the header framer.
// Assumes a 32-bit APB slave with byte addresses on an 8-bit paddr.
`ifndef SLF_MAP_SVH
`define SLF_MAP_SVH
`define SLF_A_CTRL    8'h00
`define SLF_A_STATION 8'h04
`define SLF_A_TXCMD   8'h08
`define SLF_A_STATUS  8'h0c
`define SLF_A_RXHDR   8'h10
`define SLF_A_EVENT   8'h14
`define SLF_CTRL_RST  2'h0
`define SLF_STN_RST   8'h01
`define SLF_CLS_DATA  8'h81
`define SLF_CLS_CTRL  8'h05
`define SLF_CLS_MAINT 8'h90
`define SLF_SYNC_CHAR 8'h96
`define SLF_T_ACK     8'h01
`define SLF_T_NAK     8'h02
`define SLF_T_REP     8'h03
`define SLF_T_START   8'h06
`define SLF_T_STACK   8'h07
`define SLF_P2P_ADDR  8'h01
`define SLF_WIN_MAX   8'h7f
`define SLF_HDR_LAST  3'h7
`define SLF_TX_LAST   3'h5
`define SLF_EV_NAK    0
`define SLF_EV_START  1
`define SLF_EV_STACK  2
`define SLF_EV_BAD    3
`define SLF_EV_REFUSE 4
`define SLF_EV_REP    5
`endif

// file: common/slf_pkg.sv
// Types shared by the header framer.
// Assumes slf_map.svh supplies the numeric constants.
package slf_pkg;
    typedef enum logic [1:0] {
        SLF_C_DATA  = 2'h0,
        SLF_C_CTRL  = 2'h1,
        SLF_C_MAINT = 2'h2
    } slf_cls_e;
    typedef struct packed {
        logic [5:0]  reason;
        logic [1:0]  cls;
        logic [7:0]  ctype;
        logic        sel;
        logic        qsync;
        logic [13:0] cnt;
    } slf_cmd_s;
    typedef struct packed {
        logic [7:0]  seq;
        logic [7:0]  response_number;
        logic        sel;
        logic        qsync;
        logic [13:0] cnt;
    } slf_rxhdr_s;
    typedef enum logic [2:0] {
        SLF_T_IDLE = 3'b001,
        SLF_T_SEND = 3'b010,
        SLF_T_WAIT = 3'b100
    } slf_tst_e;
    typedef enum logic [2:0] {
        SLF_R_HUNT = 3'b001,
        SLF_R_HDR  = 3'b010,
        SLF_R_INFO = 3'b100
    } slf_rst_e;
endpackage

// file: tb/slf_framer_asserts.sv
// Port assertions for the header framer.
// Assumes it is bound to slf_framer on one clock.
`timescale 1ns/1ps
module slf_framer_asserts (
    input wire logic        mclk_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [7:0]  rx_byte_i,
    input wire logic        rx_valid_i,
    input wire logic        rx_info_valid_o,
    input wire logic        rx_hunt_o,
    input wire logic [7:0]  tx_byte_o,
    input wire logic        tx_valid_o,
    input wire logic        tx_ready_i
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_access;
        psel_i && penable_i && !pready_o;
    endsequence
    sequence s_stall;
        tx_valid_o && !tx_ready_i;
    endsequence
    AST_APB_ANSWER: assert property (s_access |=> pready_o)
        else $error("apb access not answered");
    AST_PREADY_ONE: assert property (pready_o |=> !pready_o)
        else $error("pready held too long");
    AST_RDATA_IDLE: assert property (!pready_o |-> prdata_o == 32'h0)
        else $error("read data outside answer");
    AST_ERR_READY: assert property (pslverr_o |-> pready_o && $past(psel_i))
        else $error("error without answer");
    AST_TX_HOLD: assert property (s_stall |=> tx_valid_o && $stable(tx_byte_o))
        else $error("tx byte dropped while stalled");
    AST_TX_CLASS: assert property ($rose(tx_valid_o) |-> tx_byte_o inside {8'h81, 8'h05, 8'h90})
        else $error("first tx byte not a class code");
    AST_INFO_CAUSE: assert property (rx_info_valid_o |-> $past(rx_valid_i))
        else $error("info byte without line byte");
    AST_SYNC_DROP: assert property (rx_hunt_o && rx_valid_i && rx_byte_i == 8'h96 |=> !rx_info_valid_o)
        else $error("sync byte passed on");
endmodule
bind slf_framer slf_framer_asserts chk_i (.mclk_i, .rst_i, .psel_i,
    .penable_i, .prdata_o, .pready_o, .pslverr_o, .rx_byte_i, .rx_valid_i, .rx_info_valid_o,
    .rx_hunt_o, .tx_byte_o, .tx_valid_o, .tx_ready_i);

// file: tb/slf_peer.sv
// Peer station: takes header bytes, feeds line bytes.
// Assumes the framer's clock; done pulses after six bytes.
`timescale 1ns/1ps
module slf_peer (
    input  wire logic       mclk_i,
    input  wire logic [7:0] tx_byte_i,
    input  wire logic       tx_valid_i,
    output logic            tx_ready_o,
    output logic            tx_done_o,
    output logic      [7:0] rx_byte_o,
    output logic            rx_valid_o,
    output logic            rx_crc_ok_o
);
    logic [7:0] got[$];
    logic       slow = 1'b0;
    logic [2:0] n = 3'h0;
    initial begin
        {tx_ready_o, tx_done_o, rx_valid_o, rx_byte_o} = 11'h0;
        rx_crc_ok_o = 1'b1;
    end
    always @(posedge mclk_i) begin
        tx_done_o <= 1'b0;
        tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
        if (tx_valid_i && tx_ready_o) begin
            got.push_back(tx_byte_i);
            n <= (n == 3'h5) ? 3'h0 : n + 3'h1;
            tx_done_o <= (n == 3'h5);
        end
    end
    task automatic send(input logic [7:0] b);
        @(posedge mclk_i);
        rx_byte_o <= b;
        rx_valid_o <= 1'b1;
        @(posedge mclk_i);
        rx_valid_o <= 1'b0;
        rx_byte_o <= ~b;
    endtask
endmodule

// file: tb/sync_link_message_header_framer_test.sv
// Self-checking bench for the header framer.
// Assumes slf_peer on the line side and APB from the bench.
`timescale 1ns/1ps
`include "slf_map.svh"
module sync_link_message_header_framer_test;
    logic        mclk_i, rst_i, psel_i, penable_i, pwrite_i, e_r;
    logic [7:0]  paddr_i, rx_byte_i, rx_info_o, tx_byte_o;
    logic [31:0] pwdata_i, prdata_o, r;
    logic        pready_o, pslverr_o, rx_valid_i, rx_crc_ok_i, rx_info_valid_o, rx_hunt_o;
    logic        tx_valid_o, tx_ready_i, tx_done_i, link_own_o;
    logic [7:0]  info[$];
    int          num_errors, comparisons;
    slf_framer uut (.mclk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
        .prdata_o, .pready_o, .pslverr_o, .rx_byte_i, .rx_valid_i, .rx_crc_ok_i, .rx_info_o,
        .rx_info_valid_o, .rx_hunt_o, .tx_byte_o, .tx_valid_o, .tx_ready_i, .tx_done_i,
        .link_own_o);
    slf_peer peer (.mclk_i, .tx_byte_i(tx_byte_o), .tx_valid_i(tx_valid_o),
        .tx_ready_o(tx_ready_i), .tx_done_o(tx_done_i), .rx_byte_o(rx_byte_i),
        .rx_valid_o(rx_valid_i), .rx_crc_ok_o(rx_crc_ok_i));
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) if (rx_info_valid_o === 1'b1) info.push_back(rx_info_o);
    task automatic stop_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge mclk_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do begin @(posedge mclk_i); k++; end while (pready_o !== 1'b1 && k < 16);
        chk("apb answer", 1, pready_o);
        if (pready_o !== 1'b1) stop_test;
        {r, e_r} = {prdata_o, pslverr_o};
        {psel_i, penable_i} <= 2'b00;
    endtask
    task automatic txchk(input logic [47:0] e, input logic [5:0] m);
        int k = 0;
        while (peer.got.size() < 6 && k < 300) begin @(posedge mclk_i); k++; end
        if (peer.got.size() < 6) begin num_errors++; stop_test; end
        for (int i = 0; i < 6; i++) if (m[i]) chk("tx byte", e[47-8*i -: 8], peer.got[i]);
        peer.got.delete();
    endtask
    task automatic rxmsg(input logic [47:0] h, input int ni);
        for (int i = 0; i < 8; i++) peer.send(i < 6 ? h[47-8*i -: 8] : 8'h00);
        if (ni > 0) for (int i = 0; i < ni + 2; i++) peer.send(8'ha0 + i[7:0]);
    endtask
    task automatic t_regs;
        apb(0, `SLF_A_CTRL, 0);
        chk("ctrl", 32'h0, r);
        apb(0, `SLF_A_STATION, 0);
        chk("station", 32'h1, r);
        apb(1, `SLF_A_STATION, 32'h5a);
        apb(0, `SLF_A_STATION, 0);
        chk("station rw", 32'h5a, r);
        apb(1, `SLF_A_STATION, 32'h1);
        apb(0, 8'h18, 0);
        chk("unmapped err", 1, e_r);
        chk("unmapped data", 0, r);
    endtask
    task automatic t_tx_data;
        peer.slow = 1'b1;
        apb(1, `SLF_A_TXCMD, 32'h3);
        txchk(48'h81_03_00_00_01_01, 6'h3f);
        peer.slow = 1'b0;
        apb(0, `SLF_A_STATUS, 0);
        chk("last sent", 32'h1, r & 32'hff);
    endtask
    task automatic t_tx_nak;
        apb(1, `SLF_A_TXCMD, 32'h15024000);
        txchk(48'h05_02_45_00_00_01, 6'b101111);
    endtask
    task automatic t_rx_data;
        info.delete();
        rxmsg(48'h81_02_00_00_01_01, 2);
        chk("info count", 2, info.size());
        chk("info byte", 8'ha1, info[1]);
        rxmsg(48'h81_02_00_00_01_01, 2);
        apb(0, `SLF_A_STATUS, 0);
        chk("received", 32'h1, (r >> 8) & 32'hff);
    endtask
    task automatic t_rx_start;
        rxmsg(48'h05_06_40_00_00_01, 0);
        txchk(48'h05_07_00_00_00_01, 6'b101111);
        chk("hunt", 1, rx_hunt_o);
        peer.send(`SLF_SYNC_CHAR);
        apb(0, `SLF_A_EVENT, 0);
        chk("event start", 32'h2, r & 32'h3f);
        apb(0, `SLF_A_STATUS, 0);
        chk("received reset", 0, (r >> 8) & 32'hff);
        peer.send(8'h42);
        apb(0, `SLF_A_EVENT, 0);
        chk("event bad", 32'ha, r & 32'h3f);
        apb(1, `SLF_A_EVENT, 32'h3f);
        apb(0, `SLF_A_EVENT, 0);
        chk("event clear", 0, r & 32'h3f);
    endtask
    initial begin
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = 43'h0;
        {rst_i, num_errors, comparisons} = {1'b1, 32'h0, 32'h0};
        repeat (6) @(posedge mclk_i);
        rst_i <= 1'b0;
        t_regs;
        t_tx_data;
        t_tx_nak;
        t_rx_data;
        t_rx_start;
        stop_test;
    end
    initial begin
        #200000;
        num_errors++;
        stop_test;
    end
endmodule
